// File: design/dmc_pkg.sv
// package: offsets, field positions, reset values and carriers of the channel
package dmc_pkg;
	// -----------------------------------------------------------
	// register offsets within the first pci window
	// -----------------------------------------------------------
	localparam logic [11:0] OFS_OPERATION = 12'h500;
	localparam logic [11:0] OFS_CONTROL = 12'h504;
	localparam logic [11:0] OFS_XFER_COUNT = 12'h508;
	localparam logic [11:0] OFS_MEM_CONFIG = 12'h50c;
	localparam logic [11:0] OFS_MEM_ADDRESS = 12'h510;
	localparam logic [11:0] OFS_DEV_CONFIG = 12'h514;
	localparam logic [11:0] OFS_LINK_CONFIG = 12'h51c;
	localparam logic [11:0] OFS_LINK_ADDRESS = 12'h520;
	localparam logic [11:0] OFS_NODE_ADDR = 12'h528;
	localparam logic [11:0] OFS_NODE_COUNT = 12'h52c;
	localparam logic [11:0] OFS_STATE = 12'h53c;
	localparam logic [11:0] OFS_FIFO_LEVEL = 12'h540;
	// -----------------------------------------------------------
	// reset values
	// -----------------------------------------------------------
	localparam logic [31:0] RST_OPERATION = 32'h0000_0512;
	localparam logic [31:0] RST_CONTROL = 32'h5555_0000;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	// fixed bits of channel_operation: 10, 8 and 1 read one
	localparam logic [31:0] OP_FIXED_ONES = 32'h0000_0502;
	// upper half of channel_control reads an alternating pattern
	localparam logic [15:0] CTL_UPPER = 16'h5555;
	// -----------------------------------------------------------
	// field positions
	// -----------------------------------------------------------
	localparam int OP_RESET_BIT = 31;
	localparam int OP_CLEAR_DONE_CMD_BIT = 7;
	localparam int OP_FLUSH_BIT = 4;
	localparam int OP_ABORT_BIT = 3;
	localparam int OP_STOP_BIT = 2;
	localparam int OP_START_BIT = 0;
	localparam int CTL_DIR_BIT = 3;
	localparam int ST_DONE_BIT = 25;
	localparam int ST_ERROR_BIT = 15;
	localparam int ST_SABORT_BIT = 14;
	localparam int ST_STOPS_BIT = 12;
	// link short mode pattern of channel_mode_select
	localparam logic [2:0] MODE_LINK_SHORT = 3'h4;
	// -----------------------------------------------------------
	// carriers
	// -----------------------------------------------------------
	typedef struct packed {
		logic [31:0] addr; // buffer address in host memory
		logic [31:0] count; // byte count of this node
		logic [31:0] next; // next node pointer, zero ends the list
	} dmc_node_type;
	typedef struct packed {
		logic [31:0] addr; // host memory address
		logic [31:0] count; // bytes to move
		logic dir; // 0 memory to gpib, 1 gpib to memory
	} dmc_xfer_type;
	typedef enum logic [2:0] {
		SEQ_IDLE, SEQ_FETCH, SEQ_MOVE, SEQ_DRAIN
	} dmc_seq_type;
endpackage : dmc_pkg

// File: design/dmc_sequencer.sv
// file: link short node sequencer of the dma channel
`timescale 1ns/1ps
module dmc_sequencer
	import dmc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic soft_clr, // channel reset command
	input wire logic start, // one-cycle start write
	input wire logic abort_req, // abort level
	input wire logic stop_req, // stop level
	input wire logic mode_ok, // link short selected
	input wire logic dir,
	input wire logic [31:0] link_addr,
	output logic node_req,
	output logic [31:0] node_ptr,
	input wire logic node_ack,
	input wire dmc_node_type node_in,
	output logic load_node,
	output dmc_node_type node_held,
	output logic xfer_req,
	output dmc_xfer_type xfer_out,
	input wire logic xfer_done,
	input wire logic fifo_empty,
	output logic flush_evt,
	output logic busy,
	output logic done_evt,
	output logic error_evt
);
	// -----------------------------------------------------------
	// state
	// -----------------------------------------------------------
	dmc_seq_type state; // sequencer state
	dmc_seq_type next_state;
	logic next_done; // completion this cycle
	logic next_err; // completion by error
	logic next_flush; // discard fifo this cycle

	// handshake outputs decoded from state
	assign node_req = (state == SEQ_FETCH);
	assign xfer_req = (state == SEQ_MOVE);
	assign busy = (state != SEQ_IDLE);
	assign xfer_out = '{addr: node_held.addr, count: node_held.count,
		dir: dir};

	// next state and completion events
	always_comb begin
		next_state = state;
		next_done = 1'b0;
		next_err = 1'b0;
		next_flush = 1'b0;
		case (state)
			SEQ_IDLE: begin
				if (start && !mode_ok) begin
					// reserved mode: refuse and report
					next_done = 1'b1;
					next_err = 1'b1;
				end else if (start) begin
					next_state = SEQ_FETCH;
				end
			end
			SEQ_FETCH: begin
				// the node read in flight is finished even on abort or stop; only soft_clr ends it
				if (node_ack) begin
					next_state = SEQ_MOVE;
				end
			end
			SEQ_MOVE: begin
				if (xfer_done && abort_req) begin
					// transfer begun is finished, then bytes dropped
					next_state = SEQ_IDLE;
					next_flush = 1'b1;
					next_done = 1'b1;
				end else if (xfer_done && (stop_req || node_held.next == 0)) begin
					next_state = SEQ_DRAIN;
				end else if (xfer_done) begin
					next_state = SEQ_FETCH;
				end
			end
			SEQ_DRAIN: begin
				// halt after the fifo has emptied, or at once with a flush on abort
				if (abort_req) begin
					next_state = SEQ_IDLE;
					next_flush = 1'b1;
					next_done = 1'b1;
				end else if (fifo_empty) begin
					next_state = SEQ_IDLE;
					next_done = 1'b1;
				end
			end
			default: begin
				next_state = SEQ_IDLE;
			end
		endcase
	end

	// state register; soft reset returns to idle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= SEQ_IDLE;
		end else if (soft_clr) begin
			state <= SEQ_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// completion pulses registered so they are glitch free
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			done_evt <= 1'b0;
			error_evt <= 1'b0;
			flush_evt <= 1'b0;
			load_node <= 1'b0;
		end else begin
			done_evt <= next_done & ~soft_clr;
			error_evt <= next_err & ~soft_clr;
			flush_evt <= next_flush | soft_clr;
			load_node <= (state == SEQ_FETCH) & node_ack & ~soft_clr;
		end
	end

	// node pointer and the node being processed
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			node_ptr <= RST_ZERO;
			node_held <= '0;
		end else if (state == SEQ_IDLE && start) begin
			node_ptr <= link_addr;
		end else if (state == SEQ_FETCH && node_ack) begin
			node_held <= node_in;
			node_ptr <= node_in.next;
		end
	end
endmodule : dmc_sequencer

// File: design/dmc_channel_regs.sv
// file: register bank and control of the single dma channel
`timescale 1ns/1ps
module dmc_channel_regs
	import dmc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic personality_488_en, // 488.2 personality active
	input wire logic reg_wr, // one-cycle write strobe
	input wire logic reg_rd, // one-cycle read strobe
	input wire logic [11:0] reg_addr, // byte offset in first_pci_window
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	output logic node_req,
	output logic [31:0] node_ptr,
	input wire logic node_ack,
	input wire dmc_node_type node_in,
	output logic xfer_req,
	output dmc_xfer_type xfer_out,
	input wire logic xfer_done,
	input wire logic fifo_empty,
	input wire logic [31:0] fifo_count,
	output logic fifo_flush,
	output logic [31:0] transfer_count,
	output logic [31:0] memory_config,
	output logic [31:0] memory_address,
	output logic [31:0] device_config,
	output logic [31:0] link_config
);
	// -----------------------------------------------------------
	// register storage
	// -----------------------------------------------------------
	logic [31:0] link_address; // head of the node list
	logic [31:0] node_base_address; // address of current node
	logic [31:0] node_base_count; // count of current node
	logic dir; // transfer direction
	logic [2:0] channel_mode_select; // mode pattern
	logic start_bit; // reads one while running
	logic abort_bit; // abort requested
	logic stop_bit; // stop requested
	logic flush_bit; // fifo flush pending, self clearing
	logic reset_bit; // channel_reset_cmd, self clearing
	logic done; // completion status
	logic error; // completion by error
	// -----------------------------------------------------------
	// decode
	// -----------------------------------------------------------
	logic wr_op, wr_ctl; // write strobes per register
	logic start_evt; // one written to start
	logic clear_done_cmd; // one written to clear-done
	logic seq_busy, seq_done, seq_err, seq_flush, seq_load;
	dmc_node_type node_held;

	// true when a strobe hits a given offset inside the group
	function automatic logic hit(input logic strobe,
		input logic [11:0] addr, input logic [11:0] ofs);
		hit = strobe & personality_488_en & (addr == ofs);
	endfunction : hit

	assign wr_op = hit(reg_wr, reg_addr, OFS_OPERATION);
	assign wr_ctl = hit(reg_wr, reg_addr, OFS_CONTROL);
	assign start_evt = wr_op & reg_wdata[OP_START_BIT];
	assign clear_done_cmd = wr_op & reg_wdata[OP_CLEAR_DONE_CMD_BIT];

	// -----------------------------------------------------------
	// channel sequencer
	// -----------------------------------------------------------
	dmc_sequencer u_seq (
		.clk(clk),
		.rstn(rstn),
		.soft_clr(reset_bit),
		.start(start_evt & ~seq_busy),
		.abort_req(abort_bit),
		.stop_req(stop_bit),
		.mode_ok(channel_mode_select == MODE_LINK_SHORT),
		.dir(dir),
		.link_addr(link_address),
		.node_req(node_req),
		.node_ptr(node_ptr),
		.node_ack(node_ack),
		.node_in(node_in),
		.load_node(seq_load),
		.node_held(node_held),
		.xfer_req(xfer_req),
		.xfer_out(xfer_out),
		.xfer_done(xfer_done),
		.fifo_empty(fifo_empty),
		.flush_evt(seq_flush),
		.busy(seq_busy),
		.done_evt(seq_done),
		.error_evt(seq_err)
	);

	// flush from the flush command, an abort or a channel reset command; one cycle each
	assign fifo_flush = flush_bit | seq_flush;

	// -----------------------------------------------------------
	// channel_control: direction and mode only
	// -----------------------------------------------------------
	// software must set this before start; a change mid-run
	// takes effect at once on the direction presented
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dir <= RST_CONTROL[CTL_DIR_BIT];
			channel_mode_select <= RST_CONTROL[2:0];
		end else if (wr_ctl) begin
			dir <= reg_wdata[CTL_DIR_BIT];
			channel_mode_select <= reg_wdata[2:0];
		end
	end

	// -----------------------------------------------------------
	// channel_operation command bits
	// -----------------------------------------------------------
	// start clears abort and stop; a new abort or stop in the
	// same write still lands since the set is applied last
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			abort_bit <= RST_OPERATION[OP_ABORT_BIT];
			stop_bit <= RST_OPERATION[OP_STOP_BIT];
		end else begin
			if (start_evt || reset_bit) begin
				abort_bit <= 1'b0;
				stop_bit <= 1'b0;
			end
			if (wr_op && reg_wdata[OP_ABORT_BIT]) begin
				abort_bit <= 1'b1;
			end
			if (wr_op && reg_wdata[OP_STOP_BIT]) begin
				stop_bit <= 1'b1;
			end
		end
	end

	// self clearing flush and channel reset commands
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flush_bit <= RST_OPERATION[OP_FLUSH_BIT];
			reset_bit <= RST_OPERATION[OP_RESET_BIT];
		end else begin
			flush_bit <= wr_op & reg_wdata[OP_FLUSH_BIT];
			reset_bit <= wr_op & reg_wdata[OP_RESET_BIT];
		end
	end

	// start reads one from the write until completion
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			start_bit <= RST_OPERATION[OP_START_BIT];
		end else if (start_evt && !seq_busy) begin
			start_bit <= 1'b1;
		end else if (seq_done || reset_bit) begin
			start_bit <= 1'b0;
		end
	end

	// -----------------------------------------------------------
	// completion status: a set beats a clear in the same cycle
	// -----------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			done <= 1'b0;
			error <= 1'b0;
		end else begin
			done <= seq_done | (done & ~clear_done_cmd & ~start_evt
				& ~reset_bit);
			error <= seq_err | (error & ~start_evt & ~reset_bit);
		end
	end

	// -----------------------------------------------------------
	// plain configuration registers
	// -----------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			transfer_count <= RST_ZERO;
			memory_config <= RST_ZERO;
			memory_address <= RST_ZERO;
			device_config <= RST_ZERO;
			link_config <= RST_ZERO;
			link_address <= RST_ZERO;
		end else begin
			if (hit(reg_wr, reg_addr, OFS_XFER_COUNT)) begin
				transfer_count <= reg_wdata;
			end
			if (hit(reg_wr, reg_addr, OFS_MEM_CONFIG)) begin
				memory_config <= reg_wdata;
			end
			if (hit(reg_wr, reg_addr, OFS_MEM_ADDRESS)) begin
				memory_address <= reg_wdata;
			end
			if (hit(reg_wr, reg_addr, OFS_DEV_CONFIG)) begin
				device_config <= reg_wdata;
			end
			if (hit(reg_wr, reg_addr, OFS_LINK_CONFIG)) begin
				link_config <= reg_wdata;
			end
			if (hit(reg_wr, reg_addr, OFS_LINK_ADDRESS)) begin
				link_address <= reg_wdata;
			end
		end
	end

	// node registers: the node load beats a software write
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			node_base_address <= RST_ZERO;
			node_base_count <= RST_ZERO;
		end else if (seq_load) begin
			node_base_address <= node_held.addr;
			node_base_count <= node_held.count;
		end else begin
			if (hit(reg_wr, reg_addr, OFS_NODE_ADDR)) begin
				node_base_address <= reg_wdata;
			end
			if (hit(reg_wr, reg_addr, OFS_NODE_COUNT)) begin
				node_base_count <= reg_wdata;
			end
		end
	end

	// -----------------------------------------------------------
	// read path; state and fifo level have no write side
	// -----------------------------------------------------------
	logic [31:0] next_rdata; // value selected by offset
	always_comb begin
		next_rdata = RST_ZERO;
		case (reg_addr)
			OFS_OPERATION: begin
				next_rdata = OP_FIXED_ONES;
				next_rdata[OP_RESET_BIT] = reset_bit;
				next_rdata[OP_CLEAR_DONE_CMD_BIT] = 1'b0;
				next_rdata[OP_FLUSH_BIT] = flush_bit;
				next_rdata[OP_ABORT_BIT] = abort_bit;
				next_rdata[OP_STOP_BIT] = stop_bit;
				next_rdata[OP_START_BIT] = start_bit;
			end
			OFS_CONTROL: begin
				next_rdata = {CTL_UPPER, 12'h000, dir,
					channel_mode_select};
			end
			OFS_XFER_COUNT: next_rdata = transfer_count;
			OFS_MEM_CONFIG: next_rdata = memory_config;
			OFS_MEM_ADDRESS: next_rdata = memory_address;
			OFS_DEV_CONFIG: next_rdata = device_config;
			OFS_LINK_CONFIG: next_rdata = link_config;
			OFS_LINK_ADDRESS: next_rdata = link_address;
			OFS_NODE_ADDR: next_rdata = node_base_address;
			OFS_NODE_COUNT: next_rdata = node_base_count;
			OFS_STATE: begin
				// read only: writes here decode to nothing
				next_rdata[ST_DONE_BIT] = done;
				next_rdata[ST_ERROR_BIT] = error;
				next_rdata[ST_SABORT_BIT] = abort_bit;
				next_rdata[ST_STOPS_BIT] = stop_bit;
			end
			OFS_FIFO_LEVEL: next_rdata = fifo_count;
			default: next_rdata = RST_ZERO; // reserved offsets
		endcase
		if (!personality_488_en) begin
			next_rdata = RST_ZERO;
		end
	end

	// read data registered, valid one cycle after the strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= RST_ZERO;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end
endmodule : dmc_channel_regs

// File: tb/dmc_channel_assertions.sv
// checker: bus and link timing of the dma channel register bank
`timescale 1ns/1ps
module dmc_channel_checker
	import dmc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic personality_488_en,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic node_req,
	input wire logic node_ack,
	input wire logic xfer_req,
	input wire logic xfer_done,
	input wire logic [31:0] fifo_count,
	input wire logic fifo_flush,
	input wire logic [31:0] transfer_count
);
	// -----------------------------------------------------------
	// helpers
	// -----------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic take_wr; // write that the bank accepts
	logic take_rd; // read that the bank accepts
	assign take_wr = reg_wr && personality_488_en;
	assign take_rd = reg_rd && personality_488_en;
	// -----------------------------------------------------------
	// assertions
	// -----------------------------------------------------------
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read strobe got no valid pulse");
	a_rvalid_pulse: assert property (!reg_rd |=> !reg_rvalid)
		else $error("valid pulse without read strobe");
	a_absent_zero: assert property (reg_rd && !personality_488_en
		|=> reg_rdata == 32'h0)
		else $error("absent group returned data");
	a_level_read: assert property (take_rd && reg_addr == OFS_FIFO_LEVEL
		|=> reg_rdata == $past(fifo_count))
		else $error("fifo level read wrong");
	a_count_write: assert property (take_wr && reg_addr == OFS_XFER_COUNT
		|=> transfer_count == $past(reg_wdata))
		else $error("transfer count not written");
	a_absent_write: assert property (reg_wr && !personality_488_en
		|=> $stable(transfer_count))
		else $error("write taken while group absent");
	a_flush_cmd: assert property (take_wr && reg_addr == OFS_OPERATION
		&& reg_wdata[OP_FLUSH_BIT] |-> ##[1:2] fifo_flush)
		else $error("flush command gave no flush");
	a_flush_pulse: assert property (fifo_flush |=> !fifo_flush)
		else $error("flush longer than one cycle");
	a_node_hold: assert property (node_req && !node_ack |=> node_req)
		else $error("node fetch dropped early");
	a_node_next: assert property (node_req && node_ack
		|=> !node_req && xfer_req)
		else $error("node not followed by transfer");
	a_xfer_hold: assert property (xfer_req && !xfer_done |=> xfer_req)
		else $error("transfer dropped before done");
	// main scenarios reached
	c_node: cover property (node_req && node_ack);
	c_xfer: cover property (xfer_req && xfer_done);
	c_flush: cover property (!fifo_flush ##1 fifo_flush);
endmodule : dmc_channel_checker

bind dmc_channel_regs dmc_channel_checker dmc_channel_checker_i (
	.clk(clk), .rstn(rstn), .personality_488_en(personality_488_en),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.node_req(node_req), .node_ack(node_ack), .xfer_req(xfer_req),
	.xfer_done(xfer_done), .fifo_count(fifo_count),
	.fifo_flush(fifo_flush), .transfer_count(transfer_count));

// File: tb/dmc_host_model.sv
// partner: host memory holding link nodes and moving node data
`timescale 1ns/1ps
module dmc_host_model
	import dmc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic node_req,
	input wire logic [31:0] node_ptr,
	output logic node_ack,
	output dmc_node_type node_in,
	input wire logic xfer_req,
	output logic xfer_done
);
	logic [2:0] ncnt; // wait before a node answer
	logic [2:0] xcnt; // wait before a transfer ends
	// two node list; the second node is answered slowly
	function automatic dmc_node_type node_at(input logic [31:0] p);
		case (p)
			32'h100: node_at = '{32'ha000, 32'h40, 32'h200};
			32'h200: node_at = '{32'hb000, 32'h80, 32'h0};
			default: node_at = '0;
		endcase
	endfunction : node_at
	// -----------------------------------------------------------
	// node fetch; data lines toggle outside the ack so stale
	// values are never mistaken for a node
	// -----------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ncnt <= 3'h0;
			node_ack <= 1'b0;
			node_in <= '0;
		end else if (node_req && !node_ack && ncnt >= {1'b0, node_ptr[9], 1'b0}) begin
			ncnt <= 3'h0;
			node_ack <= 1'b1;
			node_in <= node_at(node_ptr);
		end else begin
			ncnt <= node_req ? ncnt + 3'h1 : 3'h0;
			node_ack <= 1'b0;
			node_in <= ~node_in;
		end
	end
	// -----------------------------------------------------------
	// node data movement, long enough for an abort to land
	// -----------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			xcnt <= 3'h0;
			xfer_done <= 1'b0;
		end else if (xfer_req && !xfer_done && xcnt == 3'h6) begin
			xcnt <= 3'h0;
			xfer_done <= 1'b1;
		end else begin
			xcnt <= (xfer_req && !xfer_done) ? xcnt + 3'h1 : 3'h0;
			xfer_done <= 1'b0;
		end
	end
endmodule : dmc_host_model

// File: tb/tb_top.sv
// testbench: register map, link transfer, abort and flush of the channel
`timescale 1ns/1ps
module tb_top;
	import dmc_pkg::*;
	typedef struct {logic [11:0] a; logic [31:0] d, e;} dmc_row_type;
	logic clk, rstn, personality_488_en, reg_wr, reg_rd, reg_rvalid;
	logic node_req, node_ack, xfer_req, xfer_done, fifo_empty, fifo_flush;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, node_ptr, fifo_count, rd_val;
	logic [31:0] out_tc, out_mc, out_ma, out_dc, out_lc; // config copies
	dmc_node_type node_in;
	dmc_xfer_type xfer_out;
	int error_cnt, comparisons, flush_n, fl0, i, n;
	// ordinary accesses: offset, written word, word read back
	dmc_row_type rows [12] = '{
		'{12'h508, 32'hffffffff, 32'hffffffff},
		'{12'h50c, 32'h12345678, 32'h12345678},
		'{12'h510, 32'ha5a5a5a5, 32'ha5a5a5a5},
		'{12'h514, 32'h0f0f0f0f, 32'h0f0f0f0f},
		'{12'h51c, 32'h1, 32'h1}, '{12'h520, 32'h100, 32'h100},
		'{12'h528, 32'hdeadbeef, 32'hdeadbeef},
		'{12'h52c, 32'h40, 32'h40},
		'{12'h504, 32'hffffffff, 32'h5555000f},
		'{12'h53c, 32'hffffffff, 32'h0}, '{12'h540, 32'hffffffff, 32'h3},
		'{12'h530, 32'hffffffff, 32'h0}};
	dmc_channel_regs dmc_channel_regs_i (.clk(clk), .rstn(rstn),
		.personality_488_en(personality_488_en), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .node_req(node_req),
		.node_ptr(node_ptr), .node_ack(node_ack), .node_in(node_in),
		.xfer_req(xfer_req), .xfer_out(xfer_out), .xfer_done(xfer_done),
		.fifo_empty(fifo_empty), .fifo_count(fifo_count),
		.fifo_flush(fifo_flush), .transfer_count(out_tc),
		.memory_config(out_mc), .memory_address(out_ma),
		.device_config(out_dc), .link_config(out_lc));
	dmc_host_model dmc_host_model_i (.clk(clk), .rstn(rstn),
		.node_req(node_req), .node_ptr(node_ptr), .node_ack(node_ack),
		.node_in(node_in), .xfer_req(xfer_req), .xfer_done(xfer_done));
	// -----------------------------------------------------------
	// clock, flush counter, watchdog
	// -----------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (rstn && fifo_flush) flush_n++;
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		conclude();
	end
	// -----------------------------------------------------------
	// tasks
	// -----------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data lands one cycle after the strobe is taken
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("read valid", {31'h0, reg_rvalid}, 32'h1);
		rd_val = reg_rdata;
	endtask : rd
	task automatic wait_xfer(input logic [31:0] a, c);
		for (n = 0; n < 100 && xfer_req !== 1'b1; n++) @(posedge clk);
		#1;
		chk("xfer addr", xfer_out.addr, a);
		chk("xfer count", xfer_out.count, c);
		chk("xfer dir", {31'h0, xfer_out.dir}, 32'h1);
		for (n = 0; n < 100 && xfer_req === 1'b1; n++) @(posedge clk);
	endtask : wait_xfer
	task automatic conclude();
		$display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	// -----------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------
	initial begin
		rstn = 1'b0;
		personality_488_en = 1'b1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		fifo_empty = 1'b1;
		fifo_count = 32'h3;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		for (i = 0; i < 12; i++) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			chk("register", rd_val, rows[i].e);
		end
		// the configuration copies follow what was written
		chk("count out", out_tc, 32'hffffffff);
		chk("mem config out", out_mc, 32'h12345678);
		chk("mem addr out", out_ma, 32'ha5a5a5a5);
		chk("dev config out", out_dc, 32'h0f0f0f0f);
		chk("link config out", out_lc, 32'h1);
		// group absent: writes dropped, reads zero
		@(posedge clk) personality_488_en <= 1'b0;
		wr(12'h508, 32'h0);
		rd(12'h508);
		chk("absent read", rd_val, 32'h0);
		@(posedge clk) personality_488_en <= 1'b1;
		rd(12'h508);
		chk("kept count", rd_val, 32'hffffffff);
		// reset in mid-run restores the documented values; the flush
		// bit resets set and clears itself at the first edge after
		fl0 = flush_n;
		@(posedge clk) rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(12'h500);
		chk("operation reset", rd_val, 32'h502);
		chk("reset flush", flush_n - fl0, 32'h1);
		rd(12'h504);
		chk("control reset", rd_val, 32'h55550000);
		rd(12'h528);
		chk("base addr reset", rd_val, 32'h0);
		rd(12'h52c);
		chk("base count reset", rd_val, 32'h0);
		// two node list, control programmed first
		wr(12'h504, 32'hc);
		wr(12'h520, 32'h100);
		@(posedge clk) fifo_empty <= 1'b0;
		wr(12'h500, 32'h1);
		wait_xfer(32'ha000, 32'h40);
		wait_xfer(32'hb000, 32'h80);
		// fifo still full: the channel must keep running
		rd(12'h500);
		chk("draining", rd_val, 32'h503);
		@(posedge clk) fifo_empty <= 1'b1;
		repeat (4) @(posedge clk);
		rd(12'h53c);
		chk("done state", rd_val & 32'h0200d000, 32'h02000000);
		rd(12'h528);
		chk("base addr", rd_val, 32'hb000);
		rd(12'h52c);
		chk("base count", rd_val, 32'h80);
		rd(12'h500);
		chk("idle operation", rd_val, 32'h502);
		wr(12'h500, 32'h80);
		rd(12'h53c);
		chk("done cleared", rd_val & 32'h02000000, 32'h0);
		fl0 = flush_n;
		wr(12'h500, 32'h10);
		repeat (3) @(posedge clk);
		chk("flush count", flush_n - fl0, 32'h1);
		// abort in mid-transfer: node finishes, no next fetch, flush
		wr(12'h504, 32'h4);
		@(posedge clk) fifo_empty <= 1'b0;
		wr(12'h500, 32'h1);
		for (n = 0; n < 100 && xfer_req !== 1'b1; n++) @(posedge clk);
		#1;
		chk("xfer dir out", {31'h0, xfer_out.dir}, 32'h0);
		fl0 = flush_n;
		wr(12'h500, 32'h8);
		for (n = 0; n < 100 && xfer_req === 1'b1; n++) @(posedge clk);
		repeat (6) @(posedge clk);
		#1;
		chk("no next node", {31'h0, node_req}, 32'h0);
		chk("abort flush", flush_n - fl0, 32'h1);
		rd(12'h53c);
		chk("abort state", rd_val & 32'h02004000, 32'h02004000);
		// reserved mode: start refused with error, abort cleared
		wr(12'h504, 32'h8);
		wr(12'h500, 32'h1);
		@(posedge clk) fifo_empty <= 1'b1;
		rd(12'h53c);
		chk("mode error", rd_val & 32'h0200c000, 32'h02008000);
		// channel reset command: one flush, done and error cleared
		fl0 = flush_n;
		wr(12'h500, 32'h80000000);
		repeat (3) @(posedge clk);
		chk("reset cmd flush", flush_n - fl0, 32'h1);
		rd(12'h53c);
		chk("reset cmd state", rd_val & 32'h0200d000, 32'h0);
		conclude();
	end
endmodule : tb_top
